//--- dv/fcs_ctrl_asserts.sv
// port assertions of the flash command sequencer
`timescale 1ns/100ps
module fcs_ctrl_asserts (
  input wire logic              i_clk,
  input wire logic              i_srst,
  input wire fcs_pkg::fcs_bus_t i_bus,
  input wire logic [31:0]       o_rdata,
  input wire logic              o_bus_wait,
  input wire logic              o_dma_req,
  input wire logic              o_ready,
  input wire logic              o_cmd_lock,
  input wire logic              o_code_pe,
  input wire logic              o_data_pe
);
  // ----
  // helpers
  // ----
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  logic cmd_w;
  logic mode_w;
  logic erase_q;
  assign cmd_w  = i_bus.wr && i_bus.addr == 8'h40;
  assign mode_w = i_bus.wr && i_bus.addr == 8'h00;
  always_ff @(posedge i_clk)
    erase_q <= cmd_w && i_bus.wdata[7:0] == 8'h20;
  // ----
  // properties
  // ----
  a_rdata_idle: assert property (!i_bus.rd |=> o_rdata == 32'h0)
    else $error("read data outside slot");
  a_code_entry: assert property (mode_w && i_bus.wdata[0] |=> o_code_pe)
    else $error("code mode missed");
  a_data_entry: assert property (mode_w && i_bus.wdata[1] |=> o_data_pe)
    else $error("data mode missed");
  a_read_mode: assert property (
    mode_w && i_bus.wdata[1:0] == 2'h0 && o_ready && !o_cmd_lock
    |=> !o_code_pe && !o_data_pe)
    else $error("read mode missed");
  a_lock_holds: assert property (
    o_cmd_lock && !(i_bus.wr && i_bus.addr inside {8'h0c, 8'h40})
    |=> o_cmd_lock)
    else $error("lock dropped");
  a_ae_release: assert property (
    i_bus.wr && i_bus.addr == 8'h0c |=> !o_cmd_lock)
    else $error("lock kept");
  a_erase_start: assert property (
    erase_q && cmd_w && i_bus.wdata[7:0] == 8'hd0 && o_data_pe
    && !o_code_pe && o_ready && !o_cmd_lock |=> !o_ready [*8])
    else $error("erase not started");
  a_wait_cause: assert property (o_bus_wait |-> cmd_w && o_code_pe)
    else $error("stray stall");
  a_dma_pulse: assert property (
    o_dma_req |-> !o_ready ##1 !o_dma_req)
    else $error("bad dma request");
  a_busy_span: assert property ($fell(o_ready) |-> !o_ready [*8])
    else $error("busy too short");
endmodule // fcs_ctrl_asserts

bind fcs_ctrl fcs_ctrl_asserts u_fcs_ctrl_asserts (
  .i_clk      (i_clk),
  .i_srst     (i_srst),
  .i_bus      (i_bus),
  .o_rdata    (o_rdata),
  .o_bus_wait (o_bus_wait),
  .o_dma_req  (o_dma_req),
  .o_ready    (o_ready),
  .o_cmd_lock (o_cmd_lock),
  .o_code_pe  (o_code_pe),
  .o_data_pe  (o_data_pe)
);

//--- dv/fcs_ctrl_tb.sv
// self-checking bench of the flash command sequencer
`timescale 1ns/100ps
module fcs_ctrl_tb;
  // ----
  // signals and instances
  // ----
  logic              i_clk;
  logic              i_srst;
  fcs_pkg::fcs_bus_t tb_bus;
  fcs_pkg::fcs_bus_t dma_bus;
  fcs_pkg::fcs_bus_t i_bus;
  logic [31:0]       o_rdata;
  logic              o_bus_wait;
  logic              o_dma_req;
  logic              o_ready;
  logic              o_cmd_lock;
  logic              o_code_pe;
  logic              o_data_pe;
  logic              dma_act;
  int                n_errors;
  int                num_checks;
  int                stalls;
  int                reqs;
  int                n;
  // the dma model owns the bus only while it transfers
  assign i_bus = dma_act ? dma_bus : tb_bus;
  fcs_ctrl u_fcs_ctrl (
    .i_clk      (i_clk),
    .i_srst     (i_srst),
    .i_bus      (i_bus),
    .o_rdata    (o_rdata),
    .o_bus_wait (o_bus_wait),
    .o_dma_req  (o_dma_req),
    .o_ready    (o_ready),
    .o_cmd_lock (o_cmd_lock),
    .o_code_pe  (o_code_pe),
    .o_data_pe  (o_data_pe)
  );
  fcs_dma_model u_fcs_dma_model (
    .i_clk     (i_clk),
    .i_srst    (i_srst),
    .i_dma_req (o_dma_req),
    .o_bus     (dma_bus),
    .o_active  (dma_act)
  );
  initial
  begin
    i_clk = 1'h0;
    forever #4 i_clk = ~i_clk;
  end
  always @(posedge i_clk)
    if (o_dma_req === 1'h1)
      reqs++;
  // ----
  // bus tasks
  // ----
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic see(string nm, ref logic v, input logic e);
    #1;
    chk(nm, {31'h0, v}, {31'h0, e});
    @(posedge i_clk);
  endtask
  // a refused write is held and offered again until taken
  task automatic wr(logic [7:0] a, logic [31:0] d);
    tb_bus <= '{a, d, 1'h1, 1'h0};
    #1;
    while (o_bus_wait === 1'h1)
    begin
      stalls++;
      @(posedge i_clk);
      #1;
    end
    @(posedge i_clk);
  endtask
  task automatic cmd(logic [7:0] c);
    wr(8'h40, {24'h0, c});
  endtask
  task automatic idle;
    tb_bus.wr <= 1'h0;
    @(posedge i_clk);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e, string nm);
    tb_bus <= '{a, 32'h0, 1'h0, 1'h1};
    @(posedge i_clk);
    tb_bus.rd <= 1'h0;
    #1;
    chk(nm, o_rdata, e);
    @(posedge i_clk);
  endtask
  task automatic wait_rdy(int lim);
    n = 0;
    #1;
    while (o_ready !== 1'h1 && n < lim)
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    @(posedge i_clk);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_id;
    rd(8'h04, 32'h1, "id_rst");
    wr(8'h00, 32'h1);
    cmd(8'h20);
    cmd(8'hd0);
    idle();
    see("code_pe", o_code_pe, 1'h1);
    see("id_refuse", o_ready, 1'h1);
    wr(8'h08, 32'h5a5ac3c3);
    rd(8'h04, 32'h0, "id_open");
  endtask
  task automatic t_err;
    cmd(8'h20);
    cmd(8'h55);
    cmd(8'h20);
    cmd(8'hd0);
    idle();
    rd(8'h10, 32'h7, "st_ill");
    cmd(8'h50);
    idle();
    rd(8'h10, 32'h1, "st_clr");
  endtask
  task automatic t_prog;
    wr(8'h1c, 32'h1);
    wr(8'h14, 32'h100);
    cmd(8'he8);
    cmd(8'h06);
    repeat (4) wr(8'h40, 32'hffffffff);
    rd(8'h10, 32'h9, "buf_full");
    repeat (2) wr(8'h40, 32'hffffffff);
    cmd(8'hd0);
    idle();
    wait_rdy(2000);
    chk("stall", 32'(stalls > 0), 32'h1);
    chk("prog", 32'(n >= 250 && n < 260), 32'h1);
  endtask
  task automatic t_ram;
    // image: two code words, word count, then their two-byte sum
    wr(8'h24, 32'h0000_1111);
    wr(8'h24, 32'h0000_2222);
    wr(8'h24, 32'h0000_0002);
    wr(8'h24, 32'h0000_3333);
    idle();
    rd(8'h10, 32'h33, "st_ram");
    cmd(8'h50);
    idle();
    see("clr_lock", o_cmd_lock, 1'h1);
    cmd(8'hb3);
    idle();
    rd(8'h10, 32'h1, "st_stop");
  endtask
  task automatic t_ae;
    wr(8'h00, 32'h0);
    idle();
    see("rd_mode", o_code_pe, 1'h0);
    cmd(8'h20);
    idle();
    rd(8'h0c, 32'h2, "ae");
    cmd(8'hb3);
    idle();
    see("ae_lock", o_cmd_lock, 1'h1);
    wr(8'h0c, 32'h0);
    idle();
    see("ae_free", o_cmd_lock, 1'h0);
  endtask
  task automatic t_erase;
    wr(8'h00, 32'h2);
    cmd(8'h50);
    wr(8'h18, 32'h1);
    wr(8'h20, 32'h1);
    wr(8'h14, 32'h2000);
    cmd(8'h20);
    cmd(8'hd0);
    idle();
    see("data_pe", o_data_pe, 1'h1);
    wait_rdy(3000);
    chk("erase", 32'(n > 2400 && n < 2600), 32'h1);
    rd(8'h10, 32'h41, "lb_on");
    wr(8'h18, 32'h0);
    cmd(8'h20);
    cmd(8'hd0);
    cmd(8'h20);
    idle();
    see("busy_lock", o_cmd_lock, 1'h1);
    repeat (8) @(posedge i_clk);
    cmd(8'hb3);
    idle();
    see("stop_rdy", o_ready, 1'h1);
    rd(8'h10, 32'h1, "lb_off");
  endtask
  task automatic t_dma;
    reqs = 0;
    wr(8'h14, 32'h3000);
    cmd(8'hea);
    cmd(8'h03);
    cmd(8'hd0);
    idle();
    wait_rdy(2000);
    chk("dma_req", 32'(reqs), 32'h3);
    rd(8'h10, 32'h1, "st_dma");
  endtask
  // ----
  // run
  // ----
  task automatic test_done;
    if (n_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    i_srst = 1'h1;
    tb_bus = '0;
    n_errors = 0;
    num_checks = 0;
    stalls = 0;
    reqs = 0;
    repeat (20) @(posedge i_clk);
    i_srst <= 1'h0;
    t_id();
    t_err();
    t_prog();
    t_ram();
    t_ae();
    t_erase();
    t_dma();
    test_done();
  end
  // runs take under 4000 cycles; this cut-off of 25000 cycles is over six times that
  initial
  begin
    #200000;
    n_errors++;
    test_done();
  end
endmodule // fcs_ctrl_tb

//--- dv/fcs_dma_model.sv
// dma controller model answering sequencer transfer requests
`timescale 1ns/100ps
module fcs_dma_model (
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  input  wire logic         i_dma_req,
  output fcs_pkg::fcs_bus_t o_bus,
  output logic              o_active
);
  logic [15:0] half_q;
  logic        second_q;
  // two halfword writes per request, low half first
  always_ff @(posedge i_clk)
  begin
    if (i_srst || !(i_dma_req || second_q))
    begin
      o_bus    <= '0;
      o_active <= 1'h0;
      second_q <= 1'h0;
      if (i_srst)
        half_q <= 16'h1234;
    end
    else
    begin
      o_bus    <= '{8'h40, {16'h0, half_q}, 1'h1, 1'h0};
      o_active <= 1'h1;
      second_q <= !second_q;
      half_q   <= half_q + 16'h1111;
    end
  end
endmodule // fcs_dma_model

//--- rtl/fcs_cfg.svh
// offsets, field positions, command codes and timing of the flash sequencer
`ifndef FCS_CFG_SVH
`define FCS_CFG_SVH

// register offsets (byte address)
`define FCS_OFS_MODE      8'h00
`define FCS_OFS_ID_LOCKED_BIT      8'h04
`define FCS_OFS_IDCMP     8'h08
`define FCS_OFS_AESTAT    8'h0c
`define FCS_OFS_STATUS    8'h10
`define FCS_OFS_SADDR     8'h14
`define FCS_OFS_PROT      8'h18
`define FCS_OFS_AREA      8'h1c
`define FCS_OFS_SUSP      8'h20
`define FCS_OFS_RAMLD     8'h24
`define FCS_OFS_CMD       8'h40

// mode entry fields
`define FCS_MODE_CODE_BIT 0
`define FCS_MODE_DATA_BIT 1

// status fields
`define FCS_ST_READY      0
`define FCS_ST_LOCK       1
`define FCS_ST_ILLEGAL    2
`define FCS_ST_BUF_FULL   3
`define FCS_ST_RAM_CORR   4
`define FCS_ST_RAM_UNCORR 5
`define FCS_ST_LB_ERASED  6

// access error fields
`define FCS_AE_CODE_BIT   0
`define FCS_AE_DATA_BIT   1

// command bytes
`define FCS_CMD_PROG      8'he8
`define FCS_CMD_DMA_PROG  8'hea
`define FCS_CMD_ERASE     8'h20
`define FCS_CMD_CONFIRM   8'hd0
`define FCS_CMD_CLEAR     8'h50
`define FCS_CMD_STOP      8'hb3

// reset values and keys; the key is arbitrary
`define FCS_RST_ID_LOCKED 1'b1
`define FCS_ID_KEY        32'h5a5a_c3c3

// buffer depth in words
`define FCS_BUF_DEPTH     3'h4

// timing
`define FCS_CLK_NS        8
`define FCS_PROG_NS       2000
`define FCS_ERASE_NS      20000
`define FCS_WORD_NS       400
`define FCS_PROG_CYC  ((`FCS_PROG_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_ERASE_CYC ((`FCS_ERASE_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_WORD_CYC  ((`FCS_WORD_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)

`endif

//--- rtl/fcs_ctrl.sv
// flash command sequencer: mode entry, lock handling and command issue
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/100ps
`include "fcs_cfg.svh"

module fcs_ctrl (
  input  wire logic             i_clk,
  input  wire logic             i_srst,
  input  wire fcs_pkg::fcs_bus_t i_bus,
  output logic [31:0]           o_rdata,
  output logic                  o_bus_wait,
  output logic                  o_dma_req,
  output logic                  o_ready,
  output logic                  o_cmd_lock,
  output logic                  o_code_pe,
  output logic                  o_data_pe
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  fcs_pkg::fcs_regs_t q;
  fcs_pkg::fcs_regs_t d;

  logic       cmd_wr;
  logic [7:0] cmd_byte;
  logic       buf_full;
  logic       ready;
  logic       release_ok;
  logic       stall;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign cmd_wr   = i_bus.wr && (i_bus.addr == `FCS_OFS_CMD);
  assign cmd_byte = i_bus.wdata[7:0];
  assign buf_full = (q.buf_cnt == `FCS_BUF_DEPTH);
  assign ready    = (q.st != fcs_pkg::FCS_BUSY) &&
                    (q.st != fcs_pkg::FCS_DMA);
  // an illegal command against a guarded area keeps the lock
  assign release_ok = !(q.illegal && (q.code_ae || q.data_ae));
  // data words are held off while the code buffer is full
  assign stall = cmd_wr && (q.st == fcs_pkg::FCS_DATA) &&
                 q.code_pe && buf_full &&
                 (cmd_byte != `FCS_CMD_STOP);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d         = q;
    d.dma_req = 1'b0;
    d.rdata   = 32'h0000_0000;

    // register reads, answered in the following cycle
    if (i_bus.rd)
    begin
      case (i_bus.addr)
        `FCS_OFS_MODE:
        begin
          d.rdata[`FCS_MODE_CODE_BIT] = q.code_pe;
          d.rdata[`FCS_MODE_DATA_BIT] = q.data_pe;
        end
        `FCS_OFS_ID_LOCKED_BIT:
          d.rdata[0] = q.id_locked;
        `FCS_OFS_AESTAT:
        begin
          d.rdata[`FCS_AE_CODE_BIT] = q.code_ae;
          d.rdata[`FCS_AE_DATA_BIT] = q.data_ae;
        end
        `FCS_OFS_STATUS:
        begin
          d.rdata[`FCS_ST_READY]      = ready;
          d.rdata[`FCS_ST_LOCK]       = q.lock;
          d.rdata[`FCS_ST_ILLEGAL]    = q.illegal;
          d.rdata[`FCS_ST_BUF_FULL]   = buf_full;
          d.rdata[`FCS_ST_RAM_CORR]   = q.ram_corr;
          d.rdata[`FCS_ST_RAM_UNCORR] = q.ram_uncorr;
          d.rdata[`FCS_ST_LB_ERASED]  = q.lb_erased;
        end
        `FCS_OFS_SADDR:
          d.rdata = q.start_addr;
        `FCS_OFS_PROT:
          d.rdata[0] = q.prot_ctl;
        `FCS_OFS_AREA:
          d.rdata[7:0] = q.area_sel;
        `FCS_OFS_SUSP:
          d.rdata[0] = q.susp_mode;
        default:
          d.rdata = 32'h0000_0000;
      endcase
    end

    // buffer drains one word per word time
    if (q.buf_cnt != 3'h0)
    begin
      if (q.drain == 12'(`FCS_WORD_CYC - 1))
      begin
        d.drain   = 12'h000;
        d.buf_cnt = q.buf_cnt - 3'h1;
      end
      else
        d.drain = q.drain + 12'h001;
    end

    // operation in flight ends when timer and buffer are spent
    if (q.st == fcs_pkg::FCS_BUSY)
    begin
      if (q.timer != 12'h000)
        d.timer = q.timer - 12'h001;
      else if (q.buf_cnt == 3'h0)
        d.st = fcs_pkg::FCS_IDLE;
    end

    // register writes
    if (i_bus.wr)
    begin
      case (i_bus.addr)
        `FCS_OFS_MODE:
        begin
          if (i_bus.wdata[1:0] == 2'h0)
          begin
            if (ready && !q.lock)
            begin
              d.code_pe = 1'b0;
              d.data_pe = 1'b0;
            end
          end
          else
          begin
            d.code_pe = i_bus.wdata[`FCS_MODE_CODE_BIT];
            d.data_pe = i_bus.wdata[`FCS_MODE_DATA_BIT];
          end
        end
        `FCS_OFS_IDCMP:
          if (i_bus.wdata == `FCS_ID_KEY)
            d.id_locked = 1'b0;
        `FCS_OFS_AESTAT:
        begin
          d.code_ae = 1'b0;
          d.data_ae = 1'b0;
          d.lock    = 1'b0;
        end
        `FCS_OFS_SADDR:
          d.start_addr = i_bus.wdata;
        `FCS_OFS_PROT:
          d.prot_ctl = i_bus.wdata[0];
        `FCS_OFS_AREA:
          d.area_sel = i_bus.wdata[7:0];
        `FCS_OFS_SUSP:
          d.susp_mode = i_bus.wdata[0];
        `FCS_OFS_RAMLD:
        begin
          // undefined ram contents trip the ecc on every load write
          d.ram_corr   = 1'b1;
          d.ram_uncorr = 1'b1;
          d.lock       = 1'b1;
        end
        default:
          d.lock = d.lock;
      endcase
    end

    // command issue area
    if (cmd_wr && !stall)
    begin
      if (cmd_byte == `FCS_CMD_STOP)
      begin
        // pure hardware path, no firmware involved
        d.st         = fcs_pkg::FCS_IDLE;
        d.timer      = 12'h000;
        d.buf_cnt    = 3'h0;
        d.drain      = 12'h000;
        d.words      = 8'h00;
        d.half       = 1'b0;
        d.ram_corr   = 1'b0;
        d.ram_uncorr = 1'b0;
        if (release_ok)
        begin
          d.illegal = 1'b0;
          d.lock    = 1'b0;
        end
      end
      else if (cmd_byte == `FCS_CMD_CLEAR && ready)
      begin
        d.ram_corr = 1'b0;
        // uncorrectable ram error survives a status clear
        if (release_ok && !q.ram_uncorr)
        begin
          d.illegal = 1'b0;
          d.lock    = 1'b0;
          d.st      = fcs_pkg::FCS_IDLE;
        end
      end
      else if (q.lock)
        d.lock = 1'b1;
      else if (q.code_pe && q.id_locked)
        d.lock = 1'b0;
      else if (!q.code_pe && !q.data_pe)
      begin
        d.data_ae = 1'b1;
        d.illegal = 1'b1;
        d.lock    = 1'b1;
      end
      else
      begin
        case (q.st)
          fcs_pkg::FCS_IDLE:
          begin
            if (cmd_byte == `FCS_CMD_PROG)
            begin
              d.op = fcs_pkg::FCS_OP_PROG;
              d.st = fcs_pkg::FCS_COUNT;
            end
            else if (cmd_byte == `FCS_CMD_DMA_PROG && q.data_pe)
            begin
              d.op = fcs_pkg::FCS_OP_DMA;
              d.st = fcs_pkg::FCS_COUNT;
            end
            else if (cmd_byte == `FCS_CMD_ERASE)
            begin
              d.op = fcs_pkg::FCS_OP_ERASE;
              d.st = fcs_pkg::FCS_ERASE;
            end
            else
            begin
              d.illegal = 1'b1;
              d.lock    = 1'b1;
            end
          end
          fcs_pkg::FCS_COUNT:
          begin
            d.words = cmd_byte;
            if (cmd_byte == 8'h00)
            begin
              d.illegal = 1'b1;
              d.lock    = 1'b1;
              d.st      = fcs_pkg::FCS_IDLE;
            end
            else if (q.op == fcs_pkg::FCS_OP_DMA)
              d.st = fcs_pkg::FCS_CONFIRM;
            else
              d.st = fcs_pkg::FCS_DATA;
          end
          fcs_pkg::FCS_DATA:
          begin
            // only code flash data passes through the buffer
            // build on d so a drain in this same cycle is not lost
            if (q.code_pe)
              d.buf_cnt = d.buf_cnt + 3'h1;
            d.words = q.words - 8'h01;
            if (q.words == 8'h01)
              d.st = fcs_pkg::FCS_CONFIRM;
          end
          fcs_pkg::FCS_CONFIRM:
          begin
            if (cmd_byte != `FCS_CMD_CONFIRM)
            begin
              d.illegal = 1'b1;
              d.lock    = 1'b1;
              d.st      = fcs_pkg::FCS_IDLE;
              d.buf_cnt = 3'h0;
            end
            else if (q.op == fcs_pkg::FCS_OP_DMA)
            begin
              d.st      = fcs_pkg::FCS_DMA;
              d.half    = 1'b0;
              d.dma_req = 1'b1;
            end
            else
            begin
              d.st    = fcs_pkg::FCS_BUSY;
              d.timer = 12'(`FCS_PROG_CYC);
            end
          end
          fcs_pkg::FCS_ERASE:
          begin
            if (cmd_byte == `FCS_CMD_CONFIRM)
            begin
              d.st    = fcs_pkg::FCS_BUSY;
              d.timer = 12'(`FCS_ERASE_CYC);
              if (q.prot_ctl)
                d.lb_erased = 1'b1;
              else
                d.lb_erased = 1'b0;
            end
            else
            begin
              d.illegal = 1'b1;
              d.lock    = 1'b1;
              d.st      = fcs_pkg::FCS_IDLE;
            end
          end
          fcs_pkg::FCS_DMA:
          begin
            // two halfword writes make one word
            d.half = !q.half;
            if (q.half)
            begin
              d.words = q.words - 8'h01;
              if (q.words == 8'h01)
              begin
                d.st    = fcs_pkg::FCS_BUSY;
                d.timer = 12'(`FCS_PROG_CYC);
              end
              else
                d.dma_req = 1'b1;
            end
          end
          fcs_pkg::FCS_BUSY:
          begin
            d.illegal = 1'b1;
            d.lock    = 1'b1;
          end
          default:
            d.st = fcs_pkg::FCS_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      q           <= '0;
      q.st        <= fcs_pkg::FCS_IDLE;
      q.op        <= fcs_pkg::FCS_OP_PROG;
      q.id_locked <= `FCS_RST_ID_LOCKED;
    end
    else
      q <= d;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_rdata    = q.rdata;
  assign o_bus_wait = stall;
  assign o_dma_req  = q.dma_req;
  assign o_ready    = ready;
  assign o_cmd_lock = q.lock;
  assign o_code_pe  = q.code_pe;
  assign o_data_pe  = q.data_pe;

endmodule // fcs_ctrl

//--- rtl/fcs_pkg.sv
// types of the flash command sequencer
package fcs_pkg;

  typedef enum logic [2:0] {
    FCS_IDLE,
    FCS_COUNT,
    FCS_DATA,
    FCS_CONFIRM,
    FCS_ERASE,
    FCS_DMA,
    FCS_BUSY
  } fcs_state_t;

  typedef enum logic [1:0] {
    FCS_OP_PROG,
    FCS_OP_DMA,
    FCS_OP_ERASE
  } fcs_op_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } fcs_bus_t;

  typedef struct packed {
    logic [31:0] rdata;
    fcs_state_t  st;
    fcs_op_t     op;
    logic        code_pe;
    logic        data_pe;
    logic        id_locked;
    logic        code_ae;
    logic        data_ae;
    logic        lock;
    logic        illegal;
    logic        ram_corr;
    logic        ram_uncorr;
    logic        lb_erased;
    logic [31:0] start_addr;
    logic        prot_ctl;
    logic [7:0]  area_sel;
    logic        susp_mode;
    logic [7:0]  words;
    logic        half;
    logic [2:0]  buf_cnt;
    logic [11:0] drain;
    logic [11:0] timer;
    logic        dma_req;
  } fcs_regs_t;

endpackage
